// ---- logic/drive_bus_pkg.sv ----
// constants, types and carriers shared by the fieldbus command decoder
package drive_bus_pkg;
   // function codes and exception answers
   localparam logic [7:0] FN_READ_HOLD = 8'h03;
   localparam logic [7:0] FN_PRESET_ONE = 8'h06;
   localparam logic [7:0] FN_PRESET_MANY = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
   localparam logic [7:0] BROADCAST = 8'h00;
   // crc-16 with reflected polynomial; a good frame leaves zero residue
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   // byte positions inside a request frame
   localparam int FR_ADDR = 0;
   localparam int FR_FUNC = 1;
   localparam int FR_REG_HI = 2;
   localparam int FR_REG_LO = 3;
   localparam int FR_QTY_HI = 4;
   localparam int FR_QTY_LO = 5;
   localparam int FR_BCOUNT = 6;
   localparam int FR_DATA0 = 7;
   // frame lengths, crc included
   localparam int LEN_FIXED = 8;
   localparam int LEN_MANY_BASE = 9;
   localparam int LEN_MANY_REPLY = 8;
   localparam int LEN_READ_BASE = 5;
   localparam int LEN_EXC = 5;
   localparam int LEN_MIN = 4;
   localparam int READ_HDR = 3;
   // command word bit positions
   localparam int CW_PRESET_LSB = 0;
   localparam int CW_PRESET_MSB = 1;
   localparam int CW_RAMP = 2;
   localparam int CW_NO_COAST = 3;
   localparam int CW_NO_QSTOP = 4;
   localparam int CW_USE_RAMP = 5;
   localparam int CW_START = 6;
   localparam int CW_RESET = 7;
   localparam int CW_JOG = 8;
   localparam int CW_RAMP2 = 9;
   localparam int CW_VALID = 10;
   localparam int CW_RELAY1 = 11;
   localparam int CW_RELAY2 = 12;
   localparam int CW_SETUP = 13;
   localparam int CW_REVERSE = 15;
   localparam logic [15:0] CW_RESET_VALUE = 16'h0000;
   // relay function options that hand the relay to the bus
   localparam logic [7:0] RELAY1_OPT = 8'h24;
   localparam logic [7:0] RELAY2_OPT = 8'h25;
   // how a bus bit combines with its digital input
   typedef enum logic [1:0] {
      GATE_DIGITAL = 2'h0,
      GATE_BUS = 2'h1,
      GATE_OR = 2'h2,
      GATE_AND = 2'h3
   } gate_sel_t;
   typedef struct packed {
      gate_sel_t coast_sel;
      gate_sel_t start_sel;
      gate_sel_t preset_sel;
      gate_sel_t setup_sel;
      gate_sel_t reverse_sel;
      logic [7:0] relay1_func;
      logic [7:0] relay2_func;
      logic multi_setup;
   } drive_cfg_t;
   typedef struct packed {
      logic no_coast;
      logic start;
      logic [1:0] preset;
      logic setup2;
      logic reverse;
      logic dc_brake_n;
   } drive_din_t;
   typedef struct packed {
      logic [1:0] preset_sel;
      logic dc_brake;
      logic coast;
      logic quick_stop;
      logic freeze;
      logic ramp_stop;
      logic run_permit;
      logic jog;
      logic ramp_set2;
      logic relay1;
      logic relay2;
      logic setup2;
      logic reverse;
      logic trip_reset;
   } drive_cmd_t;
endpackage

// ---- logic/crc16_acc.sv ----
// byte-wise crc-16 accumulator for frame check and reply trailer
`timescale 1ns/1ns
module crc16_acc
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic load,
   input wire logic [7:0] data,
   output logic [15:0] crc
);
   // one byte folded in, lsb first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ drive_bus_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   wire logic [15:0] next_crc = crc_step(crc, data);

   // accumulator register
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || (clk_en && clear))
         crc <= drive_bus_pkg::CRC_INIT;
      else if (clk_en && load)
         crc <= next_crc;
   end
endmodule

// ---- logic/drive_fieldbus_command_decoder.sv ----
// fieldbus holding-register follower and drive command word decoder
//
// Functional notes
// R01 - preset-one request writes one register, reply echoes the request exactly
// R02 - wire address N reaches register N+1; master sends number minus one
// R03 - preset-many writes consecutive registers; reply is address, function, start, count
// R04 - master sends start, count, byte count, then data high byte first
// R05 - read reply: address, function, byte count, data high byte first, crc
// R06 - two low command bits select one of four preset references
// R07 - bit 2 low gives dc brake and stop, high normal ramping
// R08 - bit 3 low shuts output off for coasting, high permits start
// R09 - bit 4 low ramps down on the quick-stop ramp
// R10 - bit 5 low holds output frequency; only speed up/down inputs change it
// R11 - while held, stop only by coast, dc brake or their inputs; here a low start bit 6 still clears run_permit while held
// R12 - bit 6 low ramps to stop, high permits start
// R13 - trip reset only on a rising edge of bit 7
// R14 - bit 8 high runs at jog speed
// R15 - bit 9 selects first or second ramp pair
// R16 - whole word ignored unless bit 10 is high
// R17 - relay 1 follows bit 11 only with relay option 36
// R18 - relay 2 follows bit 12 only with relay option 37
// R19 - bit 13 selects setup 1 or 2 only in multi-setup mode
// R20 - coast, start, preset and setup bits gate with digital inputs by selection
// R21 - bit 15 reverses only when reversing source is logic or/and
// R22 - bit 14 is ignored
`timescale 1ns/1ns
module drive_fieldbus_command_decoder
#(
   parameter int REG_DEPTH = 64,
   parameter int BUF_DEPTH = 32,
   parameter int MAX_QTY = 10,
   parameter logic [15:0] CTRL_REG_NUM = 16'h0010
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [7:0] node_addr,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_end,
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready,
   input wire drive_bus_pkg::drive_cfg_t cfg,
   input wire drive_bus_pkg::drive_din_t din,
   output drive_bus_pkg::drive_cmd_t cmd,
   output logic [15:0] cmd_word
);
   localparam int CW = $clog2(BUF_DEPTH + 1);
   localparam int BW = $clog2(BUF_DEPTH);
   localparam int AW = $clog2(REG_DEPTH);

   typedef enum logic [1:0] {
      ST_RECV = 2'h0,
      ST_CHECK = 2'h1,
      ST_WRITE = 2'h2,
      ST_REPLY = 2'h3
   } state_t;
   typedef enum logic [1:0] {
      RK_ECHO = 2'h0,
      RK_MANY = 2'h1,
      RK_READ = 2'h2,
      RK_EXC = 2'h3
   } reply_kind_t;

   state_t state;
   reply_kind_t kind;
   logic [7:0] rxbuf [BUF_DEPTH];
   logic [15:0] mem [REG_DEPTH];
   logic [CW-1:0] rx_cnt;
   logic rx_ovf;
   logic [7:0] exc_code;
   logic bcast_hold;
   logic [15:0] wr_k;
   logic [7:0] tx_idx;
   logic trip_pulse;
   logic [15:0] rx_crc;
   logic [15:0] tx_crc;

   // request fields as they sit in the frame buffer
   wire logic [7:0] f_addr = rxbuf[drive_bus_pkg::FR_ADDR];
   wire logic [7:0] f_func = rxbuf[drive_bus_pkg::FR_FUNC];
   wire logic [15:0] f_start = {rxbuf[drive_bus_pkg::FR_REG_HI], rxbuf[drive_bus_pkg::FR_REG_LO]};
   wire logic [15:0] f_qty = {rxbuf[drive_bus_pkg::FR_QTY_HI], rxbuf[drive_bus_pkg::FR_QTY_LO]};
   wire logic [7:0] f_bcount = rxbuf[drive_bus_pkg::FR_BCOUNT];

   // frame admission: length, crc residue and follower address
   wire logic bcast = (f_addr == drive_bus_pkg::BROADCAST);
   wire logic frame_ok = (rx_cnt >= CW'(drive_bus_pkg::LEN_MIN)) && !rx_ovf
      && (rx_crc == drive_bus_pkg::CRC_RESIDUE) && (bcast || f_addr == node_addr);
   wire logic len_fixed = (rx_cnt == CW'(drive_bus_pkg::LEN_FIXED));
   // preset-many length: fixed header and crc around the announced data bytes
   wire logic len_many =
      (9'(rx_cnt) == 9'(f_bcount) + 9'(drive_bus_pkg::LEN_MANY_BASE)); // [R04]
   wire logic qty_ok = (f_qty != 16'h0000) && (f_qty <= 16'(MAX_QTY));
   wire logic [16:0] span_end = {1'b0, f_start} + {1'b0, f_qty};
   wire logic span_ok = (span_end <= 17'(REG_DEPTH));
   wire logic one_ok = (f_start < 16'(REG_DEPTH));
   wire logic bcount_ok = ({8'h00, f_bcount} == {f_qty[14:0], 1'b0}); // [R04]

   // decision taken at the end of a frame
   wire logic is_read = (f_func == drive_bus_pkg::FN_READ_HOLD);
   wire logic is_one = (f_func == drive_bus_pkg::FN_PRESET_ONE);
   wire logic is_many = (f_func == drive_bus_pkg::FN_PRESET_MANY);
   wire logic chk_drop = (is_read && (!len_fixed || bcast)) || (is_one && !len_fixed)
      || (is_many && (!len_many || !bcount_ok));
   wire logic [7:0] chk_code = (!is_read && !is_one && !is_many) ? drive_bus_pkg::EXC_BAD_FUNC
      : (is_one ? (one_ok ? 8'h00 : drive_bus_pkg::EXC_BAD_ADDR)
      : (!qty_ok ? drive_bus_pkg::EXC_BAD_VALUE
      : (!span_ok ? drive_bus_pkg::EXC_BAD_ADDR : 8'h00)));

   // register write path; wire address indexes the store, register number is one more
   wire logic [15:0] wr_addr = f_start + wr_k; // [R02]
   wire logic [BW-1:0] wr_pos = BW'(drive_bus_pkg::FR_DATA0) + BW'({wr_k[14:0], 1'b0});
   wire logic [15:0] wr_word = (kind == RK_ECHO)
      ? {rxbuf[drive_bus_pkg::FR_QTY_HI], rxbuf[drive_bus_pkg::FR_QTY_LO]}
      : {rxbuf[wr_pos], rxbuf[wr_pos + BW'(1)]}; // [R04]
   wire logic wr_last = (kind == RK_ECHO) || (wr_k + 16'h0001 == f_qty);
   wire logic ctrl_hit = (wr_addr + 16'h0001 == CTRL_REG_NUM); // [R02]
   wire logic latch = (state == ST_WRITE) && ctrl_hit && wr_word[drive_bus_pkg::CW_VALID]; // [R16]

   // reply assembly
   wire logic [7:0] reply_len = (kind == RK_ECHO) ? 8'(drive_bus_pkg::LEN_FIXED)
      : (kind == RK_MANY) ? 8'(drive_bus_pkg::LEN_MANY_REPLY)
      : (kind == RK_EXC) ? 8'(drive_bus_pkg::LEN_EXC)
      : 8'(drive_bus_pkg::LEN_READ_BASE) + {f_qty[6:0], 1'b0}; // [R05]
   wire logic [7:0] rd_off = tx_idx - 8'(drive_bus_pkg::READ_HDR);
   wire logic [15:0] rd_word = mem[AW'(f_start + {9'h000, rd_off[7:1]})];
   wire logic in_crc = (tx_idx + 8'h02 >= reply_len);
   wire logic [7:0] crc_byte = (tx_idx + 8'h02 == reply_len) ? tx_crc[7:0] : tx_crc[15:8];
   wire logic [7:0] body_byte = (kind == RK_ECHO || kind == RK_MANY || tx_idx == 8'h00)
      ? rxbuf[BW'(tx_idx)]
      : (tx_idx == 8'h01) ? (kind == RK_EXC ? (f_func | drive_bus_pkg::EXC_FLAG) : f_func)
      : (tx_idx == 8'h02) ? (kind == RK_EXC ? exc_code : {f_qty[6:0], 1'b0})
      : (rd_off[0] ? rd_word[7:0] : rd_word[15:8]); // [R05]
   wire logic [7:0] reply_byte = (kind != RK_ECHO && in_crc) ? crc_byte : body_byte; // [R01] [R03]
   wire logic tx_take = (state == ST_REPLY) && (!tx_valid || tx_ready);
   wire logic tx_more = (tx_idx < reply_len);

   // frame check crc over received bytes
   crc16_acc rx_crc_u
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .clear(state != ST_RECV),
      .load(state == ST_RECV && rx_valid),
      .data(rx_data),
      .crc(rx_crc)
   );

   // trailer crc over reply bytes
   crc16_acc tx_crc_u
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .clear(state != ST_REPLY),
      .load(tx_take && tx_more && !in_crc),
      .data(reply_byte),
      .crc(tx_crc)
   );

   // receive buffer; bytes outside a receive phase are dropped
   always_ff @(posedge ref_clk)
   begin
      if (clk_en && state == ST_RECV && rx_valid && rx_cnt < CW'(BUF_DEPTH))
         rxbuf[BW'(rx_cnt)] <= rx_data;
   end

   // holding register store
   always_ff @(posedge ref_clk)
   begin
      if (clk_en && state == ST_WRITE)
         mem[AW'(wr_addr)] <= wr_word; // [R01] [R03]
   end

   // frame sequencer
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         state <= ST_RECV;
         kind <= RK_ECHO;
         rx_cnt <= '0;
         rx_ovf <= 1'b0;
         exc_code <= 8'h00;
         bcast_hold <= 1'b0;
         wr_k <= 16'h0000;
      end
      else if (clk_en)
      begin
         case (state)
            ST_RECV:
            begin
               if (rx_valid && rx_cnt < CW'(BUF_DEPTH))
                  rx_cnt <= rx_cnt + CW'(1);
               else if (rx_valid)
                  rx_ovf <= 1'b1;
               if (rx_end)
                  state <= ST_CHECK;
            end
            ST_CHECK:
            begin
               bcast_hold <= bcast;
               exc_code <= chk_code;
               wr_k <= 16'h0000;
               if (!frame_ok || chk_drop)
                  state <= ST_RECV;
               else if (chk_code != 8'h00)
               begin
                  kind <= RK_EXC;
                  state <= bcast ? ST_RECV : ST_REPLY;
               end
               else if (is_read)
               begin
                  kind <= RK_READ;
                  state <= ST_REPLY;
               end
               else
               begin
                  kind <= is_one ? RK_ECHO : RK_MANY;
                  state <= ST_WRITE;
               end
            end
            ST_WRITE:
            begin
               wr_k <= wr_k + 16'h0001; // [R03]
               if (wr_last)
                  state <= bcast_hold ? ST_RECV : ST_REPLY;
            end
            ST_REPLY:
            begin
               if (tx_take && !tx_more)
                  state <= ST_RECV;
            end
            default:
               state <= ST_RECV;
         endcase
         if (state != ST_RECV)
         begin
            rx_cnt <= '0;
            rx_ovf <= 1'b0;
         end
      end
   end

   // reply byte stream with ready back-pressure
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         tx_data <= 8'h00;
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
         tx_idx <= 8'h00;
      end
      else if (clk_en)
      begin
         if (state != ST_REPLY)
            tx_idx <= 8'h00;
         else if (tx_take)
         begin
            tx_valid <= tx_more;
            tx_data <= tx_more ? reply_byte : 8'h00;
            tx_last <= (tx_idx + 8'h01 == reply_len);
            tx_idx <= tx_more ? tx_idx + 8'h01 : tx_idx;
         end
      end
   end

   // accepted command word and trip reset edge
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         cmd_word <= drive_bus_pkg::CW_RESET_VALUE;
         trip_pulse <= 1'b0;
      end
      else if (clk_en)
      begin
         trip_pulse <= latch && wr_word[drive_bus_pkg::CW_RESET]
            && !cmd_word[drive_bus_pkg::CW_RESET]; // [R13]
         if (latch)
            cmd_word <= wr_word; // [R16]
      end
   end

   // gate a bus bit with its digital input
   function automatic logic gate_bit(input drive_bus_pkg::gate_sel_t sel, input logic bus_b,
      input logic din_b);
      case (sel)
         drive_bus_pkg::GATE_DIGITAL: gate_bit = din_b;
         drive_bus_pkg::GATE_BUS: gate_bit = bus_b;
         drive_bus_pkg::GATE_OR: gate_bit = bus_b | din_b;
         drive_bus_pkg::GATE_AND: gate_bit = bus_b & din_b;
         default: gate_bit = din_b;
      endcase
   endfunction

   // command decode; bit 14 takes no part [R22]
   wire logic no_coast_g = gate_bit(cfg.coast_sel, cmd_word[drive_bus_pkg::CW_NO_COAST],
      din.no_coast); // [R20] [R08]
   wire logic start_g = gate_bit(cfg.start_sel, cmd_word[drive_bus_pkg::CW_START],
      din.start); // [R20] [R12]
   wire logic [1:0] preset_g = {
      gate_bit(cfg.preset_sel, cmd_word[drive_bus_pkg::CW_PRESET_MSB], din.preset[1]),
      gate_bit(cfg.preset_sel, cmd_word[drive_bus_pkg::CW_PRESET_LSB], din.preset[0])}; // [R06]
   wire logic setup_g = gate_bit(cfg.setup_sel, cmd_word[drive_bus_pkg::CW_SETUP],
      din.setup2); // [R20]
   wire logic rev_bus = cmd_word[drive_bus_pkg::CW_REVERSE];
   wire logic rev_g = (cfg.reverse_sel == drive_bus_pkg::GATE_OR) ? (rev_bus | din.reverse)
      : (cfg.reverse_sel == drive_bus_pkg::GATE_AND) ? (rev_bus & din.reverse)
      : din.reverse; // [R21]
   wire logic hold_g = !cmd_word[drive_bus_pkg::CW_USE_RAMP]; // [R10]
   wire logic brake_g = !cmd_word[drive_bus_pkg::CW_RAMP] || !din.dc_brake_n; // [R07] [R11]
   wire logic qstop_g = !cmd_word[drive_bus_pkg::CW_NO_QSTOP] && !hold_g; // [R09] [R11]
   wire logic rstop_g = !start_g && !hold_g; // [R12] [R11]
   drive_bus_pkg::drive_cmd_t next_cmd;
   assign next_cmd.preset_sel = preset_g;
   assign next_cmd.dc_brake = brake_g;
   assign next_cmd.coast = !no_coast_g; // [R08]
   assign next_cmd.quick_stop = qstop_g;
   assign next_cmd.freeze = hold_g;
   assign next_cmd.ramp_stop = rstop_g;
   assign next_cmd.run_permit = no_coast_g && start_g && !brake_g && !qstop_g;
   assign next_cmd.jog = cmd_word[drive_bus_pkg::CW_JOG]; // [R14]
   assign next_cmd.ramp_set2 = cmd_word[drive_bus_pkg::CW_RAMP2]; // [R15]
   assign next_cmd.relay1 = (cfg.relay1_func == drive_bus_pkg::RELAY1_OPT)
      && cmd_word[drive_bus_pkg::CW_RELAY1]; // [R17]
   assign next_cmd.relay2 = (cfg.relay2_func == drive_bus_pkg::RELAY2_OPT)
      && cmd_word[drive_bus_pkg::CW_RELAY2]; // [R18]
   assign next_cmd.setup2 = cfg.multi_setup && setup_g; // [R19]
   assign next_cmd.reverse = rev_g;
   assign next_cmd.trip_reset = trip_pulse; // [R13]

   // registered command outputs
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         cmd <= '0;
      else if (clk_en)
         cmd <= next_cmd;
   end

   // checks
   write_one_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R01]
      clk_en && state == ST_WRITE && kind == RK_ECHO |=> mem[AW'($past(wr_addr))] == $past(wr_word))
      else $error("single preset not stored");
   ctrl_map_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R02]
      clk_en && latch |-> wr_addr == CTRL_REG_NUM - 16'h0001)
      else $error("command word latched from wrong address");
   many_len_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R03]
      tx_valid && tx_last && kind == RK_MANY |-> tx_idx == 8'h08)
      else $error("multi preset reply length wrong");
   read_len_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R05]
      state == ST_REPLY && kind == RK_READ |-> reply_len == 8'h05 + {f_qty[6:0], 1'b0})
      else $error("read reply length wrong");
   valid_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R16]
      clk_en && $changed(cmd_word) |-> $past(cmd_word[drive_bus_pkg::CW_VALID]) || cmd_word[10])
      else $error("invalid command word accepted");
   reset_edge_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R13]
      clk_en && cmd.trip_reset |-> $past(cmd_word[7], 2) == 1'b0 || !$past(clk_en))
      else $error("trip reset without rising edge");
   hold_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R11]
      cmd.freeze |-> !cmd.ramp_stop && !cmd.quick_stop)
      else $error("ramp stop while output held");
   relay_opt_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R17]
      clk_en && cmd_word[11] && cfg.relay1_func != 8'h24 |=> !cmd.relay1)
      else $error("relay 1 driven without bus option");
   coast_bus_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R08]
      clk_en && cfg.coast_sel == drive_bus_pkg::GATE_BUS && !cmd_word[3] |=> cmd.coast
      && !cmd.run_permit)
      else $error("bus coast did not release output");
endmodule

// ---- tb/bus_master_model.sv ----
// request-sending master that frames bytes with crc and stalls on replies
`timescale 1ns/1ns
module bus_master_model
(
   input wire logic ref_clk,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_end,
   output logic tx_ready
);
   int seed = 32'h524C;
   initial
   begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_end = 1'b0;
      tx_ready = 1'b0;
   end
   // random ready stalls, ready low about one cycle in four, so some reply bytes have to stand
   always @(posedge ref_clk)
   begin
      #1 tx_ready = ($random(seed) & 3) != 0;
   end
   // crc-16, reflected, low byte goes first on the wire
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction
   // one byte per cycle, then a separate end-of-frame pulse
   task automatic send(input logic [7:0] q[$]);
      logic [15:0] c;
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i])
      begin
         @(posedge ref_clk);
         #1 rx_data = q[i];
         rx_valid = 1'b1;
      end
      @(posedge ref_clk);
      #1 rx_valid = 1'b0;
      rx_data = ~rx_data; // released line shows no stale byte
      rx_end = 1'b1;
      @(posedge ref_clk);
      #1 rx_end = 1'b0;
   endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the fieldbus command decoder
`timescale 1ns/1ns
module tb_top;
   localparam logic [15:0] CREG = 16'h0010;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] rx_data, tx_data;
   logic rx_valid, rx_end, tx_valid, tx_last, tx_ready;
   drive_bus_pkg::drive_cfg_t cfg = '0;
   drive_bus_pkg::drive_din_t din = '0;
   drive_bus_pkg::drive_cmd_t cmd;
   logic [15:0] cmd_word, cw, pw, c;
   logic [7:0] exp_q[$];
   logic [7:0] req[$];
   logic [31:0] r;
   logic [1:0] s;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   int pulses = 0;
   int seed = 32'h524C;
   always #5 ref_clk = ~ref_clk;
   drive_fieldbus_command_decoder #(.CTRL_REG_NUM(CREG)) dut (.ref_clk(ref_clk), .rstn(rstn),
      .clk_en(1'b1), .node_addr(8'h01), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_end(rx_end), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
      .tx_ready(tx_ready), .cfg(cfg), .din(din), .cmd(cmd), .cmd_word(cmd_word));
   bus_master_model master (.ref_clk(ref_clk), .tx_data(tx_data), .tx_valid(tx_valid),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .tx_ready(tx_ready));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic gate(input logic [1:0] g, input logic b, input logic d);
      case (g)
         2'h0: gate = d;
         2'h1: gate = b;
         2'h2: gate = b | d;
         default: gate = b & d;
      endcase
   endfunction
   // reply monitor: oldest note against every byte taken, plus timeout and pulse count
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         bad_count++;
         tally_and_finish();
      end
      if (cmd.trip_reset === 1'b1)
         pulses <= pulses + 1;
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         check(exp_q.size() > 0, 1'b1);
         if (exp_q.size() > 0)
            check(tx_data, exp_q.pop_front());
         check(tx_last, exp_q.size() == 0);
      end
   end
   // note the reply with its crc, send the request, wait for the reply to drain
   task automatic run(input logic [7:0] rep[$]);
      c = master.crc16(rep);
      exp_q = {rep, c[7:0], c[15:8]};
      master.send(req);
      for (int n = 0; n < 300 && exp_q.size() != 0; n++)
         @(posedge ref_clk);
      check(exp_q.size(), 16'h0000);
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic preset_one(input logic [15:0] v);
      req = {8'h01, drive_bus_pkg::FN_PRESET_ONE, 8'h00, 8'h0F, v[15:8], v[7:0]};
      run({req});
   endtask
   initial
   begin
      repeat (5) @(posedge ref_clk);
      #1 rstn = 1'b1;
      cfg.start_sel = drive_bus_pkg::GATE_BUS;
      // random words under every coast, preset, setup and reverse gating selection (start from the bus), relay options on and off
      for (int i = 0; i < 8; i++)
      begin
         s = i[1:0];
         r = $random(seed);
         din = r[6:0];
         cw = r[31:16];
         cw[10] = 1'b1;
         cw[7] = 1'b0;
         cfg.coast_sel = drive_bus_pkg::gate_sel_t'(s);
         cfg.preset_sel = drive_bus_pkg::gate_sel_t'(i < 4 ? 2'h1 : s);
         if (i < 4)
            cw[1:0] = s;
         cfg.setup_sel = drive_bus_pkg::gate_sel_t'(s);
         cfg.reverse_sel = drive_bus_pkg::gate_sel_t'(s);
         cfg.multi_setup = i[2];
         cfg.relay1_func = s[0] ? drive_bus_pkg::RELAY1_OPT : 8'h23;
         cfg.relay2_func = s[1] ? drive_bus_pkg::RELAY2_OPT : 8'h00;
         preset_one(cw);
         check(cmd_word, cw);
         check(cmd.preset_sel, {gate(cfg.preset_sel, cw[1], din.preset[1]),
            gate(cfg.preset_sel, cw[0], din.preset[0])});
         check(cmd.dc_brake, !cw[2] | !din.dc_brake_n);
         check(cmd.coast, !gate(s, cw[3], din.no_coast));
         check(cmd.run_permit, gate(s, cw[3], din.no_coast) & cw[6] & cw[2] & din.dc_brake_n
            & (cw[4] | !cw[5]));
         check(cmd.quick_stop, !cw[4] & cw[5]);
         check(cmd.freeze, !cw[5]);
         check(cmd.ramp_stop, !cw[6] & cw[5]);
         check(cmd.jog, cw[8]);
         check(cmd.ramp_set2, cw[9]);
         check(cmd.relay1, cw[11] & s[0]);
         check(cmd.relay2, cw[12] & s[1]);
         check(cmd.setup2, i[2] & gate(s, cw[13], din.setup2));
         check(cmd.reverse, s[1] ? gate(s, cw[15], din.reverse) : din.reverse);
         pw = cw;
         preset_one(~pw & 16'hFB7F);
         check(cmd_word, pw);
         check(cmd.jog, pw[8]);
      end
      // reset bit: rising edge pulses once, a steady one does not
      pulses = 0;
      preset_one(16'h0480);
      preset_one(16'h0480);
      check(pulses, 1);
      req = {8'h01, drive_bus_pkg::FN_READ_HOLD, 8'h00, 8'h0F, 8'h00, 8'h01};
      run({8'h01, 8'h03, 8'h02, 8'h04, 8'h80});
      req = {8'h01, drive_bus_pkg::FN_READ_HOLD, 8'h00, 8'h00, 8'h00, 8'h00};
      run({8'h01, drive_bus_pkg::FN_READ_HOLD | drive_bus_pkg::EXC_FLAG,
         drive_bus_pkg::EXC_BAD_VALUE});
      r = $random(seed);
      req = {8'h01, drive_bus_pkg::FN_PRESET_MANY, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04,
         r[31:24], r[23:16], r[15:8], r[7:0]};
      run({8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02});
      req = {8'h01, drive_bus_pkg::FN_READ_HOLD, 8'h00, 8'h00, 8'h00, 8'h02};
      run({8'h01, 8'h03, 8'h04, r[31:24], r[23:16], r[15:8], r[7:0]});
      tally_and_finish();
   end
endmodule
